// ### design/gpdd_top.sv
`timescale 1ns/1ps
`include "gpdd_cfg.svh"
module gpdd_top
    import gpdd_pkg::*;
#(
    parameter int NPORTS = `GPDD_NPORTS  // number of port slices
) (
    input  wire logic                  CLOCK,       // system clock, 10 MHz
    input  wire logic                  ARST_N,      // async reset, low
    input  wire logic                  CYC_I,       // wishbone cycle
    input  wire logic                  STB_I,       // wishbone strobe
    input  wire logic                  WE_I,        // wishbone write
    input  wire logic [`GPDD_AW-1:0]   ADR_I,       // wishbone byte address
    input  wire logic [31:0]           DAT_I,       // wishbone write data
    input  wire logic [3:0]            SEL_I,       // wishbone byte selects
    output logic      [31:0]           DAT_O,       // wishbone read data
    output logic                       ACK_O,       // wishbone acknowledge
    input  wire logic [NPORTS*8-1:0]   PIN_IN,      // pad input levels
    output logic      [NPORTS*8-1:0]   PIN_OUT,     // pad output values
    output logic      [NPORTS*8-1:0]   PIN_OE,      // pad output enables
    input  wire logic [NPORTS*8-1:0]   ALT_OUT,     // peripheral output values
    input  wire logic [NPORTS*8-1:0]   ALT_OE,      // peripheral output enables
    output logic      [NPORTS*8-1:0]   ALT_IN,      // pin levels to peripherals
    output logic      [NPORTS*8-1:0]   PULL_UP,     // pull-up select per pad
    output logic      [NPORTS*8-1:0]   PULL_DOWN,   // pull-down select per pad
    output logic      [NPORTS*8-1:0]   DIG_EN,      // digital enable per pad
    output logic                       JTAG_TRST_N  // test-reset to debug logic
);
    // ==========================================================
    // helpers
    // reset pattern of each slice: debug pins on ports B and C
    function automatic logic [7:0] dbg_mask(input int p);
        if (p == `GPDD_PORT_B) begin
            return `GPDD_DBG_MASK_B;
        end else if (p == `GPDD_PORT_C) begin
            return `GPDD_DBG_MASK_C;
        end
        return `GPDD_CFG_RST;
    endfunction

    // whole-device debug pin pattern
    function automatic logic [NPORTS*8-1:0] dbg_all_mask();
        logic [NPORTS*8-1:0] m;
        m = '0;
        for (int p = 0; p < NPORTS; p++) begin
            m[p*8 +: 8] = dbg_mask(p);
        end
        return m;
    endfunction

    localparam logic [NPORTS*8-1:0] DBG_ALL = dbg_all_mask();

    // ==========================================================
    // pin synchronisers
    logic [NPORTS*8-1:0] pin_meta_reg;  // first stage, read only by second
    logic [NPORTS*8-1:0] pin_sync_reg;  // second stage, safe to use

    // two flops before any logic looks at a pad
    // debug pins reset high, their pulled-up idle level, so that the
    // test-reset output shows no false low pulse after a reset
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_meta_reg <= DBG_ALL;
            pin_sync_reg <= DBG_ALL;
        end else begin
            pin_meta_reg <= PIN_IN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ==========================================================
    // wishbone slave
    logic                    ack_reg;    // acknowledge
    logic [31:0]             dat_reg;    // registered read data
    logic                    req_new;    // fresh request this cycle
    logic [2:0]              port_sel;   // addressed slice
    logic                    port_ok;    // slice exists
    gpdd_req_t               req_base;   // request without strobe
    logic [NPORTS-1:0][7:0]  rd_port;    // read data of each slice
    logic [7:0]              rd_sel;     // read data of addressed slice

    assign req_new  = CYC_I && STB_I && !ack_reg;
    assign port_sel = ADR_I[`GPDD_PSEL_HI:`GPDD_PSEL_LO];
    assign port_ok  = (32'(port_sel) < NPORTS);
    assign req_base.stb  = 1'b0;
    assign req_base.off  = ADR_I[`GPDD_OFF_HI:0];
    assign req_base.mask = ADR_I[`GPDD_MASK_HI:`GPDD_MASK_LO];
    assign req_base.data = DAT_I[7:0];

    // read data of the addressed slice, zero when unmapped
    always_comb begin
        rd_sel = `GPDD_CFG_RST;
        if (port_ok) begin
            rd_sel = rd_port[port_sel];
        end
    end

    // one-wait-state answer; unmapped reads give zero
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= req_new;
            if (req_new && !WE_I) begin
                dat_reg <= {24'h000000, rd_sel};
            end
        end
    end

    assign ACK_O = ack_reg;
    assign DAT_O = dat_reg;

    // ==========================================================
    // port slices
    logic [NPORTS*8-1:0] afsel_all;  // alternate select, all pins
    logic [NPORTS*8-1:0] dir_all;    // direction, all pins
    logic [NPORTS*8-1:0] pdr_all;    // pull-down, all pins
    logic [NPORTS*8-1:0] value_all;  // data register, all pins

    // identical slices, differing only in reset pattern
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        gpdd_req_t req_p;  // request steered to this slice
        gpdd_cfg_t cfg_p;  // its configuration

        always_comb begin
            req_p     = req_base;
            req_p.stb = req_new && WE_I && SEL_I[0] && (32'(port_sel) == p);
        end

        gpdd_port #(
            .DBG_MASK (dbg_mask(p))
        ) gpdd_port_i (
            .clk      (CLOCK),
            .arst_n   (ARST_N),
            .req      (req_p),
            .pin_sync (pin_sync_reg[p*8 +: 8]),
            .alt_out  (ALT_OUT[p*8 +: 8]),
            .alt_oe   (ALT_OE[p*8 +: 8]),
            .cfg      (cfg_p),
            .value    (value_all[p*8 +: 8]),
            .rd_data  (rd_port[p]),
            .pin_out  (PIN_OUT[p*8 +: 8]),
            .pin_oe   (PIN_OE[p*8 +: 8])
        );

        assign afsel_all[p*8 +: 8] = cfg_p.afsel;
        assign dir_all[p*8 +: 8]   = cfg_p.dir;
        assign pdr_all[p*8 +: 8]   = cfg_p.pdr;
        assign PULL_UP[p*8 +: 8]   = cfg_p.pur;
        assign PULL_DOWN[p*8 +: 8] = cfg_p.pdr;
        assign DIG_EN[p*8 +: 8]    = cfg_p.den;
        assign ALT_IN[p*8 +: 8]    = pin_sync_reg[p*8 +: 8] & cfg_p.den;
    end

    // ==========================================================
    // debug test-reset
    // b7 feeds test-reset while in alt use; a low level resets debug
    assign JTAG_TRST_N = afsel_all[`GPDD_TRST_BIT] ? pin_sync_reg[`GPDD_TRST_BIT] : 1'b1;

    // ==========================================================
    // checks
    logic [2:0] up_cnt_reg;  // cycles since reset release, saturating

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            up_cnt_reg <= 3'h0;
        end else if (up_cnt_reg != `GPDD_UP_SAT) begin
            up_cnt_reg <= up_cnt_reg + 3'h1;
        end
    end

    reset_undriven_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg == 3'h0) |-> ((PIN_OE & ~DBG_ALL) == '0) && ((DIG_EN & ~DBG_ALL) == '0)
            && ((afsel_all & ~DBG_ALL) == '0) && ((PULL_UP & ~DBG_ALL) == '0))
        else $error("ordinary pin not at default after reset");

    debug_default_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg == 3'h0) |-> ((afsel_all & DBG_ALL) == DBG_ALL)
            && ((DIG_EN & DBG_ALL) == DBG_ALL) && ((PULL_UP & DBG_ALL) == DBG_ALL))
        else $error("debug pin not at debug default after reset");

    reset_restore_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg == 3'h0) |-> (pdr_all == '0) && (afsel_all == DBG_ALL))
        else $error("reset did not restore configuration");

    dir_reset_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg == 3'h0) |-> (dir_all == '0) ##1 (PIN_OE & ~DBG_ALL) == '0)
        else $error("direction not all inputs after reset");

    trst_follow_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg == `GPDD_UP_SAT) && afsel_all[`GPDD_TRST_BIT]
            && !$past(PIN_IN[`GPDD_TRST_BIT], 2) |-> !JTAG_TRST_N)
        else $error("low test-reset pin not passed on");

    input_capture_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg == `GPDD_UP_SAT) |->
            ((value_all & ~$past(dir_all)) == ($past(PIN_IN, 3) & ~$past(dir_all))))
        else $error("input bit did not capture pin level");

    output_drive_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg != 3'h0) |->
            ((PIN_OUT & $past(dir_all & ~afsel_all)) == $past(value_all & dir_all & ~afsel_all))
            && ((PIN_OE & ~$past(afsel_all)) == $past(dir_all & ~afsel_all)))
        else $error("output bit not driven from data register");

    alt_control_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        (up_cnt_reg != 3'h0) |->
            ((PIN_OUT & $past(afsel_all)) == $past(ALT_OUT & afsel_all))
            && ((PIN_OE & $past(afsel_all)) == $past(ALT_OE & afsel_all)))
        else $error("alternate pin not under peripheral control");

    mask_read_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        req_new && !WE_I && !ADR_I[`GPDD_DATA_BIT] |=>
            ACK_O && ((DAT_O[7:0] & ~$past(ADR_I[`GPDD_MASK_HI:`GPDD_MASK_LO])) == 8'h00))
        else $error("masked data bit read as nonzero");

    mask_write_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        req_new && WE_I && SEL_I[0] && port_ok && !ADR_I[`GPDD_DATA_BIT] |=>
            (((value_all ^ $past(value_all)) & $past(dir_all)
                & ~($past(32'(ADR_I[`GPDD_MASK_HI:`GPDD_MASK_LO]))
                    << ($past(32'(port_sel)) * 8))) == '0))
        else $error("write changed an unmasked output bit");
endmodule

// ### include/gpdd_cfg.svh
`ifndef GPDD_CFG_SVH
`define GPDD_CFG_SVH
// ==========================================================
// port layout
`define GPDD_NPORTS      7
`define GPDD_PW          8
`define GPDD_PORT_B      1
`define GPDD_PORT_C      2
`define GPDD_TRST_BIT    15
`define GPDD_DBG_MASK_B  8'h80
`define GPDD_DBG_MASK_C  8'h0f
`define GPDD_CFG_RST     8'h00
// ==========================================================
// register offsets inside one port window
`define GPDD_OFF_DIR     12'h400
`define GPDD_OFF_AFSEL   12'h404
`define GPDD_OFF_PUR     12'h408
`define GPDD_OFF_PDR     12'h40c
`define GPDD_OFF_DEN     12'h410
`define GPDD_OFF_PINS    12'h414
// ==========================================================
// address fields
`define GPDD_AW          15
`define GPDD_DATA_BIT    10
`define GPDD_MASK_HI     9
`define GPDD_MASK_LO     2
`define GPDD_OFF_HI      11
`define GPDD_PSEL_HI     14
`define GPDD_PSEL_LO     12
`define GPDD_UP_SAT      3'h4
`endif

// ### include/gpdd_pkg.sv
package gpdd_pkg;
    // ==========================================================
    // one bus access broadcast to the port slices
    typedef struct packed {
        logic       stb;   // write strobe for this slice
        logic [11:0] off;  // offset inside the port window
        logic [7:0] mask;  // per-bit mask from address
        logic [7:0] data;  // write data, low byte
    } gpdd_req_t;

    // ==========================================================
    // configuration state of one slice
    typedef struct packed {
        logic [7:0] afsel; // alt_function_select
        logic [7:0] den;   // digital_input_enable
        logic [7:0] pur;   // pull_up_select
        logic [7:0] pdr;   // pull_down_select
        logic [7:0] dir;   // pin_direction_reg
    } gpdd_cfg_t;
endpackage

// ### design/gpdd_port.sv
`timescale 1ns/1ps
`include "gpdd_cfg.svh"
module gpdd_port
    import gpdd_pkg::*;
#(
    parameter logic [7:0] DBG_MASK = `GPDD_CFG_RST  // bits that reset into debug use
) (
    input  wire logic      clk,       // system clock
    input  wire logic      arst_n,    // async reset, low
    input  wire gpdd_req_t req,       // bus access
    input  wire logic [7:0] pin_sync, // synchronised pin levels
    input  wire logic [7:0] alt_out,  // peripheral output value
    input  wire logic [7:0] alt_oe,   // peripheral output enable
    output gpdd_cfg_t      cfg,       // configuration registers
    output logic [7:0]     value,     // pin_value_reg
    output logic [7:0]     rd_data,   // read data for req.off
    output logic [7:0]     pin_out,   // pad output value
    output logic [7:0]     pin_oe     // pad output enable
);
    // ==========================================================
    // storage
    gpdd_cfg_t  cfg_reg;      // configuration
    logic [7:0] value_reg;    // data register
    logic [7:0] value_next;   // next data register
    logic [7:0] out_reg;      // registered pad value
    logic [7:0] oe_reg;       // registered pad enable
    logic       data_hit;     // write lands in data window

    assign data_hit = req.stb && !req.off[`GPDD_DATA_BIT];

    // configuration writes; debug bits reset into debug use
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg.afsel <= DBG_MASK;
            cfg_reg.den   <= DBG_MASK;
            cfg_reg.pur   <= DBG_MASK;
            cfg_reg.pdr   <= `GPDD_CFG_RST;
            cfg_reg.dir   <= `GPDD_CFG_RST;
        end else if (req.stb) begin
            if (req.off == `GPDD_OFF_DIR) begin
                cfg_reg.dir <= req.data;
            end else if (req.off == `GPDD_OFF_AFSEL) begin
                cfg_reg.afsel <= req.data;
            end else if (req.off == `GPDD_OFF_PUR) begin
                cfg_reg.pur <= req.data;
            end else if (req.off == `GPDD_OFF_PDR) begin
                cfg_reg.pdr <= req.data;
            end else if (req.off == `GPDD_OFF_DEN) begin
                cfg_reg.den <= req.data;
            end
        end
    end

    // inputs capture the pin, outputs keep the masked write
    always_comb begin
        value_next = value_reg;
        if (data_hit) begin
            value_next = (req.data & req.mask) | (value_reg & ~req.mask);
        end
        value_next = (cfg_reg.dir & value_next) | (~cfg_reg.dir & pin_sync);
    end

    // data register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            value_reg <= `GPDD_CFG_RST;
        end else begin
            value_reg <= value_next;
        end
    end

    // pad drive: peripheral owns alt pins, else direction and data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= `GPDD_CFG_RST;
            oe_reg  <= `GPDD_CFG_RST;
        end else begin
            out_reg <= (cfg_reg.afsel & alt_out) | (~cfg_reg.afsel & value_reg);
            oe_reg  <= (cfg_reg.afsel & alt_oe) | (~cfg_reg.afsel & cfg_reg.dir);
        end
    end

    // read mux; unmasked data bits read as zero
    always_comb begin
        if (!req.off[`GPDD_DATA_BIT]) begin
            rd_data = value_reg & req.mask;
        end else if (req.off == `GPDD_OFF_DIR) begin
            rd_data = cfg_reg.dir;
        end else if (req.off == `GPDD_OFF_AFSEL) begin
            rd_data = cfg_reg.afsel;
        end else if (req.off == `GPDD_OFF_PUR) begin
            rd_data = cfg_reg.pur;
        end else if (req.off == `GPDD_OFF_PDR) begin
            rd_data = cfg_reg.pdr;
        end else if (req.off == `GPDD_OFF_DEN) begin
            rd_data = cfg_reg.den;
        end else if (req.off == `GPDD_OFF_PINS) begin
            rd_data = pin_sync;
        end else begin
            rd_data = `GPDD_CFG_RST;
        end
    end

    assign cfg     = cfg_reg;
    assign value   = value_reg;
    assign pin_out = out_reg;
    assign pin_oe  = oe_reg;
endmodule

// ### verif/gpdd_board_model.sv
`timescale 1ns/1ps
// ==========================================================
// board devices and pads on the far side of the port pins
module gpdd_board_model (
    input  wire logic        clk,       // system clock
    input  wire logic        rst_n,     // reset as the board sees it
    input  wire logic [55:0] pin_out,   // pad output values
    input  wire logic [55:0] pin_oe,    // pad output enables
    input  wire logic [55:0] pull_up,   // pull-up selects
    input  wire logic [55:0] pull_down, // pull-down selects
    input  wire logic [55:0] ext_val,   // level a board device drives
    input  wire logic [55:0] ext_en,    // board device drives the pin
    output logic      [55:0] level      // resolved pin level
);
    logic flip_reg; // floating pins wander, so no stale value survives
    // pattern for pins that nobody drives or pulls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flip_reg <= 1'b0;
        end else begin
            flip_reg <= ~flip_reg;
        end
    end
    // resolve every pin: pad driver, board device, pull, then float
    always_comb begin
        for (int i = 0; i < 56; i++) begin
            if (pin_oe[i]) begin
                level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                level[i] = ext_val[i];
            end else if (pull_up[i]) begin
                level[i] = 1'b1;
            end else if (pull_down[i]) begin
                level[i] = 1'b0;
            end else begin
                level[i] = flip_reg ^ i[0];
            end
        end
        // keep port B bit seven high while the part is in reset
        if (!rst_n) begin
            level[15] = 1'b1;
        end
    end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "gpdd_cfg.svh"
module tb_top;
    // ==========================================================
    // signals
    logic        CLOCK, ARST_N, CYC_I, STB_I, WE_I, ACK_O, JTAG_TRST_N; // bus and control
    logic [14:0] ADR_I;                                                 // byte address
    logic [31:0] DAT_I, DAT_O;                                          // bus data
    logic [3:0]  SEL_I;                                                 // byte selects
    logic [55:0] PIN_IN, PIN_OUT, PIN_OE, ALT_OUT, ALT_OE, ALT_IN;      // pad side
    logic [55:0] PULL_UP, PULL_DOWN, DIG_EN, ext_val, ext_en;           // pad config, board
    int          n_mismatch, comparisons;                               // report counters
    localparam logic [55:0] DBG_PINS = {32'h0, `GPDD_DBG_MASK_C, `GPDD_DBG_MASK_B, 8'h00};
    // ==========================================================
    // design and board
    gpdd_top gpdd_top_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .DAT_O(DAT_O),
        .ACK_O(ACK_O), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .ALT_IN(ALT_IN), .PULL_UP(PULL_UP),
        .PULL_DOWN(PULL_DOWN), .DIG_EN(DIG_EN), .JTAG_TRST_N(JTAG_TRST_N));
    gpdd_board_model gpdd_board_model_i (.clk(CLOCK), .rst_n(ARST_N), .pin_out(PIN_OUT),
        .pin_oe(PIN_OE), .pull_up(PULL_UP), .pull_down(PULL_DOWN), .ext_val(ext_val),
        .ext_en(ext_en), .level(PIN_IN));
    // clock, 100 ns period
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    // ==========================================================
    // tasks
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; ack and read data taken at a rising edge, released there
    task automatic wb(input logic [14:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge CLOCK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= w;
        ADR_I <= a;
        DAT_I <= {24'h0, d};
        SEL_I <= 4'h1;
        do begin
            @(posedge CLOCK);
            n++;
            if (n > 50) begin
                n_mismatch++;
                end_of_test();
            end
        end while (ACK_O !== 1'b1);
        q = DAT_O[7:0];
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] q;
        wb(a, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask
    function automatic logic [14:0] ra(input int p, input logic [11:0] off);
        return {p[2:0], off};
    endfunction
    task automatic do_reset();
        @(posedge CLOCK);
        ARST_N <= 1'b0;
        repeat (6) @(posedge CLOCK);
        ARST_N <= 1'b1;
    endtask
    task automatic chk_defaults();
        @(negedge CLOCK);
        chk(JTAG_TRST_N, 1'b1);
        chk(PIN_OE, 56'h0);
        chk(PULL_DOWN, 56'h0);
        chk(PULL_UP, DBG_PINS);
        chk(DIG_EN, DBG_PINS);
        for (int p = 0; p < 7; p++) begin
            rdc(ra(p, `GPDD_OFF_AFSEL), DBG_PINS[p*8+:8]);
            rdc(ra(p, `GPDD_OFF_DIR), 8'h00);
        end
        chk(JTAG_TRST_N, 1'b1);
        chk(ALT_IN, DBG_PINS);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {ARST_N, CYC_I, STB_I, WE_I} <= 4'h0;
        {ADR_I, DAT_I, SEL_I} <= '0;
        {ALT_OUT, ALT_OE, ext_val, ext_en} <= '0;
        n_mismatch = 0;
        comparisons = 0;
        do_reset();
        chk_defaults();
        // board pulls the test-reset pin low
        @(posedge CLOCK);
        ext_en <= 56'h00000000008000;
        repeat (5) @(negedge CLOCK);
        chk(JTAG_TRST_N, 1'b0);
        // port A outputs, full then masked write and masked read
        wr(ra(0, `GPDD_OFF_DIR), 8'hff);
        wr(ra(0, 12'h3fc), 8'ha5);
        repeat (2) @(negedge CLOCK);
        chk(PIN_OUT[7:0], 8'ha5);
        chk(PIN_OE[7:0], 8'hff);
        wr(ra(0, 12'h098), 8'h00);
        repeat (2) @(negedge CLOCK);
        chk(PIN_OUT[7:0], 8'h81);
        rdc(ra(0, 12'h0c4), 8'h01);
        // port D inputs, captured level wins over a write
        @(posedge CLOCK);
        ext_en  <= 56'h000000ff008000;
        ext_val <= 56'h0000005a000000;
        repeat (5) @(negedge CLOCK);
        rdc(ra(3, 12'h3fc), 8'h5a);
        wr(ra(3, 12'h3fc), 8'hff);
        rdc(ra(3, 12'h3fc), 8'h5a);
        // low nibble of port A handed to the peripheral
        @(posedge CLOCK);
        ALT_OUT <= 56'h0c;
        ALT_OE  <= 56'h0f;
        wr(ra(0, `GPDD_OFF_AFSEL), 8'h0f);
        repeat (2) @(negedge CLOCK);
        chk(PIN_OUT[7:0], 8'h8c);
        chk(PIN_OE[7:0], 8'hff);
        // port B bit seven back to plain use releases test reset
        wr(ra(1, `GPDD_OFF_AFSEL), 8'h00);
        repeat (2) @(negedge CLOCK);
        chk(JTAG_TRST_N, 1'b1);
        // each slice keeps its own pull-down setting
        for (int p = 0; p < 7; p++) wr(ra(p, `GPDD_OFF_PDR), 8'(p + 1));
        @(negedge CLOCK);
        for (int p = 0; p < 7; p++) chk(PULL_DOWN[p*8+:8], 8'(p + 1));
        // unmapped slice is acked and reads zero
        wr(ra(7, `GPDD_OFF_DIR), 8'hff);
        rdc(ra(7, `GPDD_OFF_DIR), 8'h00);
        // reset in mid-run brings every default back
        @(posedge CLOCK);
        ext_en <= 56'h0;
        do_reset();
        chk_defaults();
        // pads stay undriven long after the reset; values of undriven pads are free
        chk(PIN_OE, 56'h0);
        end_of_test();
    end
endmodule
